// *** design/adc_readout_pkg.sv ***
// Constants, types and helpers shared by the result readout port
package adc_readout_pkg;

    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int RESULT_W = 18;
    localparam int NUM_CH = 8;
    localparam int HALF_CH = 4;
    localparam int BUS_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int SERIAL_BITS = 18;
    localparam int BYTES_PER_RESULT = 3;
    localparam int RATIO_W = 8;

    // ----------------------------------------
    // Bus line positions
    // ----------------------------------------
    localparam int LINE_MODE_IN = 15;
    localparam int LINE_ORDER_IN = 14;
    localparam int LINE_SER_B = 8;
    localparam int LINE_SER_A = 7;

    // ----------------------------------------
    // Reset values, last-index limits and special codes
    // ----------------------------------------
    localparam logic [BUS_W-1:0] BUS_RELEASED = 16'hFFFF;
    localparam logic [BUS_W-1:0] BUS_ZERO = 16'h0000;
    localparam logic [RATIO_W-1:0] RATIO_RESET = 8'h01;
    localparam logic [2:0] OS_INVALID = 3'h7;
    localparam logic [4:0] SER_LAST_BIT = 5'h11;
    localparam logic [1:0] LAST_BYTE = 2'h2;
    localparam logic [2:0] LAST_CH = 3'h7;
    localparam logic [1:0] LAST_SER_CH = 2'h3;

    typedef enum logic [1:0] {
        MODE_WORD = 2'b00,
        MODE_BYTE = 2'b01,
        MODE_SERIAL = 2'b10
    } mode_t;

    typedef enum logic {
        CONV_IDLE = 1'b0,
        CONV_BUSY = 1'b1
    } conv_state_t;

    // Pins from the host, all outside the core clock domain
    typedef struct packed {
        logic chip_select_b;
        logic read_or_sclk;
        logic interface_select;
        logic bus15_in;
        logic bus14_in;
        logic start_a;
        logic start_b;
        logic [2:0] oversample_select;
    } pin_in_t;

    // Data bus drive: oe_n low means the line is driven
    typedef struct packed {
        logic [BUS_W-1:0] data;
        logic [BUS_W-1:0] oe_n;
    } bus_drive_t;

    function automatic logic [RATIO_W-1:0] ratio_of(input logic [2:0] os);
        if (os == OS_INVALID) begin
            ratio_of = RATIO_RESET;
        end else begin
            ratio_of = RATIO_RESET << os;
        end
    endfunction

    function automatic logic [7:0] byte_of(input logic [RESULT_W-1:0] r, input logic [1:0] idx);
        case (idx)
            2'h0: byte_of = r[17:10];
            2'h1: byte_of = r[9:2];
            default: byte_of = {r[1:0], 6'h00};
        endcase
    endfunction

endpackage

// *** design/adc_result_readout_port.sv ***
// Result readout port with its result FIFO
`timescale 1ns/10ps

// ----------------------------------------
// Result FIFO
// ----------------------------------------
module result_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;
    logic [AW:0] next_count;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
        end else begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
            count <= next_count;
            // Registered so the ready seen by the source comes from a flop
            in_ready <= (next_count != (AW+1)'(DEPTH));
        end
    end
endmodule

// Operation
// - Decode three select inputs, bit 2 most significant, into the filter ratio.
// - Raise busy after rising edges seen on both convert-start inputs.
// - Ignore convert-start transitions while busy is high.
// - Keep busy high until all eight results sit in output registers.
// - First-channel flag leaves high impedance when chip select falls.
// - Word mode: flag set on first read edge, cleared on third.
// - Byte mode: flag high for three read edges, cleared on fourth.
// - Serial mode: flag rises when chip select falls, falls on 18th clock fall.
// - Word mode: lines 15,14 carry bits 17,16 then bits 1,0.
// - Word mode: lines 15 and 14 driven only while chip select low.
// - Interface select high: line 15 input picks serial (low) or byte (high).
// - Byte mode: line 14 picks byte order, high means most significant first.
// - Word mode: lines 13..9 carry bits 15..11 while select and read low.
// - Word mode: lines 8..0 carry bits 10..2, then zeros on second read.
// - Byte mode: line 8 stays in high impedance.
// - Byte mode: bytes on lines 7..0, three reads per result.
// - Serial mode: channels 1-4 on output A, channels 5-8 on output B.
// - Interface select low chooses parallel word mode.
// - Serial mode: chip select fall drives both outputs with the first MSB.
// - Chip select rising releases every data output line.
module adc_result_readout_port (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [2:0] oversample_select,
    input wire logic convert_start_a,
    input wire logic convert_start_b,
    input wire logic interface_select,
    input wire logic chip_select_b,
    input wire logic read_or_sclk,
    input wire logic bus15_or_serial_byte_choice,
    input wire logic bus14_or_byte_order,
    input wire logic sample_valid,
    input wire logic [adc_readout_pkg::RESULT_W-1:0] sample_data,
    output logic sample_ready,
    output adc_readout_pkg::bus_drive_t bus_drive,
    output logic first_channel_flag,
    output logic first_channel_flag_oe_n,
    output logic busy,
    output logic [adc_readout_pkg::RATIO_W-1:0] filter_ratio
);
    import adc_readout_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    pin_in_t pin_raw;
    pin_in_t pin_meta;
    pin_in_t pin_sync;
    pin_in_t pin_prev;

    assign pin_raw = '{chip_select_b: chip_select_b, read_or_sclk: read_or_sclk,
                       interface_select: interface_select, bus15_in: bus15_or_serial_byte_choice,
                       bus14_in: bus14_or_byte_order, start_a: convert_start_a,
                       start_b: convert_start_b, oversample_select: oversample_select};

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta <= '{chip_select_b: 1'b1, read_or_sclk: 1'b1, default: '0};
            pin_sync <= '{chip_select_b: 1'b1, read_or_sclk: 1'b1, default: '0};
            pin_prev <= '{chip_select_b: 1'b1, read_or_sclk: 1'b1, default: '0};
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    logic cs_fall;
    logic cs_rise;
    logic strobe_fall;
    logic start_a_rise;
    logic start_b_rise;
    logic frame_open;

    assign cs_fall = pin_prev.chip_select_b && !pin_sync.chip_select_b;
    assign cs_rise = !pin_prev.chip_select_b && pin_sync.chip_select_b;
    assign frame_open = !pin_sync.chip_select_b && !pin_prev.chip_select_b;
    assign strobe_fall = frame_open && pin_prev.read_or_sclk && !pin_sync.read_or_sclk;
    assign start_a_rise = !pin_prev.start_a && pin_sync.start_a;
    assign start_b_rise = !pin_prev.start_b && pin_sync.start_b;

    // ----------------------------------------
    // Oversampling ratio
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            filter_ratio <= RATIO_RESET;
        end else begin
            filter_ratio <= ratio_of(pin_sync.oversample_select);
        end
    end

    // ----------------------------------------
    // Conversion control and result registers
    // ----------------------------------------
    conv_state_t conv_state;
    logic seen_a;
    logic seen_b;
    logic [2:0] load_ch;
    logic [RESULT_W-1:0] result_reg [NUM_CH];
    logic fifo_valid;
    logic [RESULT_W-1:0] fifo_data;
    logic drain;

    // Old results stay put while a frame is open, so the FIFO backs up into the source
    assign drain = (conv_state == CONV_BUSY) && pin_sync.chip_select_b;

    result_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .in_valid(sample_valid),
        .in_data(sample_data),
        .in_ready(sample_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(drain)
    );

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            conv_state <= CONV_IDLE;
            seen_a <= 1'b0;
            seen_b <= 1'b0;
            load_ch <= '0;
            busy <= 1'b0;
        end else begin
            case (conv_state)
                CONV_IDLE: begin
                    seen_a <= seen_a || start_a_rise;
                    seen_b <= seen_b || start_b_rise;
                    if ((seen_a || start_a_rise) && (seen_b || start_b_rise)) begin
                        conv_state <= CONV_BUSY;
                        busy <= 1'b1;
                        seen_a <= 1'b0;
                        seen_b <= 1'b0;
                        load_ch <= '0;
                    end
                end
                CONV_BUSY: begin
                    // Start edges are not looked at here
                    if (drain && fifo_valid) begin
                        load_ch <= load_ch + 1'b1;
                        if (load_ch == LAST_CH) begin
                            conv_state <= CONV_IDLE;
                            busy <= 1'b0;
                        end
                    end
                end
                default: begin
                    conv_state <= CONV_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_CH; i++) begin
                result_reg[i] <= '0;
            end
        end else if (drain && fifo_valid) begin
            result_reg[load_ch] <= fifo_data;
        end
    end

    // ----------------------------------------
    // Readout frame
    // ----------------------------------------
    mode_t mode;
    logic msb_first;
    logic [2:0] rd_ch;
    logic [1:0] part;
    logic [1:0] ser_ch;
    logic [4:0] ser_bit;
    logic [RESULT_W-1:0] shift_a;
    logic [RESULT_W-1:0] shift_b;
    mode_t pin_mode;
    logic [1:0] byte_idx;

    always_comb begin
        if (!pin_sync.interface_select) begin
            pin_mode = MODE_WORD;
        end else if (pin_sync.bus15_in) begin
            pin_mode = MODE_BYTE;
        end else begin
            pin_mode = MODE_SERIAL;
        end
    end

    assign byte_idx = msb_first ? part : LAST_BYTE - part;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode <= MODE_WORD;
            msb_first <= 1'b1;
            rd_ch <= '0;
            part <= '0;
            ser_ch <= '0;
            ser_bit <= '0;
            shift_a <= '0;
            shift_b <= '0;
        end else if (cs_fall) begin
            // Mode and byte order are taken once per frame
            mode <= pin_mode;
            msb_first <= pin_sync.bus14_in;
            rd_ch <= '0;
            part <= '0;
            ser_ch <= '0;
            ser_bit <= '0;
            shift_a <= result_reg[0];
            shift_b <= result_reg[HALF_CH];
        end else if (strobe_fall) begin
            case (mode)
                MODE_WORD: begin
                    part <= {1'b0, ~part[0]};
                    rd_ch <= part[0] ? rd_ch + 1'b1 : rd_ch;
                end
                MODE_BYTE: begin
                    part <= (part == LAST_BYTE) ? 2'h0 : part + 1'b1;
                    rd_ch <= (part == LAST_BYTE) ? rd_ch + 1'b1 : rd_ch;
                end
                MODE_SERIAL: begin
                    if (ser_bit == SER_LAST_BIT) begin
                        ser_bit <= '0;
                        ser_ch <= ser_ch + 1'b1;
                        shift_a <= result_reg[{1'b0, ser_ch + 1'b1}];
                        shift_b <= result_reg[{1'b1, ser_ch + 1'b1}];
                    end else begin
                        ser_bit <= ser_bit + 1'b1;
                        shift_a <= {shift_a[RESULT_W-2:0], 1'b0};
                        shift_b <= {shift_b[RESULT_W-2:0], 1'b0};
                    end
                end
                default: begin
                    part <= '0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // First-channel flag
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            first_channel_flag <= 1'b0;
            first_channel_flag_oe_n <= 1'b1;
        end else begin
            first_channel_flag_oe_n <= pin_sync.chip_select_b;
            if (cs_fall) begin
                first_channel_flag <= (pin_mode == MODE_SERIAL);
            end else if (strobe_fall) begin
                case (mode)
                    MODE_WORD: first_channel_flag <= (rd_ch == 3'h0);
                    MODE_BYTE: first_channel_flag <= (rd_ch == 3'h0);
                    MODE_SERIAL: begin
                        if (ser_bit == SER_LAST_BIT) begin
                            first_channel_flag <= 1'b0;
                        end
                    end
                    default: first_channel_flag <= 1'b0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Data bus drive
    // ----------------------------------------
    logic [RESULT_W-1:0] cur;
    logic read_low;

    assign cur = result_reg[rd_ch];
    assign read_low = !pin_sync.chip_select_b && !pin_sync.read_or_sclk;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_drive.data <= BUS_ZERO;
            bus_drive.oe_n <= BUS_RELEASED;
        end else if (pin_sync.chip_select_b || cs_rise || cs_fall) begin // Mode not yet latched here
            bus_drive.oe_n <= BUS_RELEASED;
        end else begin
            bus_drive.oe_n <= BUS_RELEASED;
            case (mode)
                MODE_WORD: begin
                    bus_drive.oe_n[15:14] <= 2'b00;
                    bus_drive.oe_n[13:0] <= {14{!read_low}};
                    if (strobe_fall) begin
                        if (!part[0]) begin
                            bus_drive.data <= cur[17:2];
                        end else begin
                            bus_drive.data <= {cur[1:0], 14'h0000};
                        end
                    end
                end
                MODE_BYTE: begin
                    // Lines 15 and 14 are inputs, line 8 stays released
                    bus_drive.oe_n[7:0] <= {8{!read_low}};
                    if (strobe_fall) begin
                        bus_drive.data <= {8'h00, byte_of(cur, byte_idx)};
                    end
                end
                MODE_SERIAL: begin
                    bus_drive.oe_n[LINE_SER_A] <= 1'b0;
                    bus_drive.oe_n[LINE_SER_B] <= 1'b0;
                    bus_drive.data <= BUS_ZERO;
                    bus_drive.data[LINE_SER_A] <= shift_a[RESULT_W-1];
                    bus_drive.data[LINE_SER_B] <= shift_b[RESULT_W-1];
                end
                default: begin
                    bus_drive.data <= BUS_ZERO;
                end
            endcase
        end
    end
endmodule

// *** bench/host_model.sv ***
// Host controller model that frames reads with chip select and strobes
`timescale 1ns/10ps
module host_model (
    output logic chip_select_b,
    output logic read_or_sclk
);
    event take;

    initial begin
        chip_select_b = 1'b1;
        read_or_sclk = 1'b1;
    end

    // ----------------------------------------
    // Frame of n strobes or serial clocks
    // ----------------------------------------
    // The 7 ns start offset keeps every pin change clear of the core clock edge
    // Serial clock idles low so the first rise samples the MSB; period 320 ns
    task automatic frame(input int n, input bit ser);
        #7 read_or_sclk = ~ser;
        #200 chip_select_b = 1'b0;
        #200;
        repeat (n) begin
            read_or_sclk = ser;
            if (ser)
                ->take;
            #(ser ? 160 : 240);
            if (!ser)
                ->take;
            read_or_sclk = ~ser;
            #160;
        end
        chip_select_b = 1'b1;
        #200;
    endtask
endmodule

// *** bench/readout_checker.sv ***
// Concurrent checks on the pins of the result readout port
`timescale 1ns/10ps
module readout_checker (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [2:0] oversample_select,
    input wire logic convert_start_a,
    input wire logic convert_start_b,
    input wire logic interface_select,
    input wire logic chip_select_b,
    input wire logic read_or_sclk,
    input wire logic bus15_or_serial_byte_choice,
    input wire adc_readout_pkg::bus_drive_t bus_drive,
    input wire logic first_channel_flag,
    input wire logic first_channel_flag_oe_n,
    input wire logic busy,
    input wire logic [adc_readout_pkg::RATIO_W-1:0] filter_ratio
);
    import adc_readout_pkg::*;

    logic [2:0] os_prev;
    logic [3:0] os_age;
    logic prev_a, prev_b, seen_a, seen_b;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            os_prev <= 3'h0;
            os_age <= 4'h0;
        end else begin
            os_prev <= oversample_select;
            if (oversample_select != os_prev)
                os_age <= 4'h0;
            else if (os_age != 4'hF)
                os_age <= os_age + 4'h1;
        end
    end

    // Start edges seen while idle; cleared once busy so ignored edges never count
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_a <= 1'b0;
            prev_b <= 1'b0;
            seen_a <= 1'b0;
            seen_b <= 1'b0;
        end else begin
            prev_a <= convert_start_a;
            prev_b <= convert_start_b;
            seen_a <= !busy && (seen_a || (convert_start_a && !prev_a));
            seen_b <= !busy && (seen_b || (convert_start_b && !prev_b));
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_ratio_decode: assert property (os_age >= 4'h6 && oversample_select == os_prev |->
        filter_ratio == ((oversample_select == 3'h7) ? 8'h01 : 8'h01 << oversample_select)) else $error("ratio");
    a_busy_cause: assert property ($rose(busy) |-> seen_a && seen_b) else $error("busy cause");
    a_no_restart: assert property ($fell(busy) |-> (!busy)[*3]) else $error("busy restart");
    a_busy_length: assert property ($rose(busy) |=> busy[*7]) else $error("busy short");
    a_flag_drive: assert property ((!chip_select_b)[*5] |-> !first_channel_flag_oe_n) else $error("flag oe");
    a_word_upper: assert property ((!interface_select && !chip_select_b)[*5] |->
        bus_drive.oe_n[15:14] == 2'b00) else $error("upper lines");
    a_word_lower: assert property ((!interface_select && !chip_select_b && !read_or_sclk)[*6] |->
        bus_drive.oe_n[13:0] == 14'h0000) else $error("lower lines");
    a_line15_input: assert property (interface_select[*8] |-> &bus_drive.oe_n[15:14])
        else $error("line 15 driven");
    a_byte_high: assert property ((interface_select && bus15_or_serial_byte_choice)[*8] |->
        &bus_drive.oe_n[15:8]) else $error("byte high lines");
    a_serial_lines: assert property ((interface_select && !bus15_or_serial_byte_choice && !chip_select_b)[*6]
        |-> bus_drive.oe_n == 16'hFE7F) else $error("serial lines");
    a_release_all: assert property (chip_select_b[*5] |->
        first_channel_flag_oe_n && (&bus_drive.oe_n)) else $error("release");

    c_conversion: cover property ($rose(busy));
    c_flag_fall: cover property ($fell(first_channel_flag));
    c_byte_read: cover property (interface_select && bus15_or_serial_byte_choice && !read_or_sclk);
    c_serial_clock: cover property (interface_select && !bus15_or_serial_byte_choice && read_or_sclk);
endmodule

bind adc_result_readout_port readout_checker u_chk (.core_clk(core_clk), .rst_b(rst_b),
    .oversample_select(oversample_select), .convert_start_a(convert_start_a), .convert_start_b(convert_start_b),
    .interface_select(interface_select), .chip_select_b(chip_select_b), .read_or_sclk(read_or_sclk),
    .bus15_or_serial_byte_choice(bus15_or_serial_byte_choice), .bus_drive(bus_drive),
    .first_channel_flag(first_channel_flag), .first_channel_flag_oe_n(first_channel_flag_oe_n),
    .busy(busy), .filter_ratio(filter_ratio));

// *** bench/tb.sv ***
// Self-checking bench for the result readout port
`timescale 1ns/10ps
module tb;
    import adc_readout_pkg::*;
    typedef struct packed {logic [15:0] d; logic [15:0] m; logic f;} exp_t;

    logic core_clk, rst_b, convert_start_a, convert_start_b, interface_select, ord;
    logic chip_select_b, read_or_sclk, bus15_or_serial_byte_choice, bus14_or_byte_order;
    logic sample_valid, sample_ready, first_channel_flag, first_channel_flag_oe_n, busy;
    logic [2:0] oversample_select;
    logic [RESULT_W-1:0] sample_data;
    logic [RESULT_W-1:0] res [32];
    logic [RATIO_W-1:0] filter_ratio;
    bus_drive_t bus_drive;
    exp_t exp_q[$];
    int checks, mismatches, n;

    host_model u_host (.chip_select_b(chip_select_b), .read_or_sclk(read_or_sclk));

    adc_result_readout_port u_dut (.core_clk(core_clk), .rst_b(rst_b), .oversample_select(oversample_select),
        .convert_start_a(convert_start_a), .convert_start_b(convert_start_b), .interface_select(interface_select),
        .chip_select_b(chip_select_b), .read_or_sclk(read_or_sclk),
        .bus15_or_serial_byte_choice(bus15_or_serial_byte_choice), .bus14_or_byte_order(bus14_or_byte_order),
        .sample_valid(sample_valid), .sample_data(sample_data), .sample_ready(sample_ready),
        .bus_drive(bus_drive), .first_channel_flag(first_channel_flag),
        .first_channel_flag_oe_n(first_channel_flag_oe_n), .busy(busy), .filter_ratio(filter_ratio));

    // ----------------------------------------
    // Checking tasks
    // ----------------------------------------
    task automatic compare_val(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic compare_bus(input exp_t e);
        compare_val({bus_drive.data & e.m, bus_drive.oe_n & e.m, first_channel_flag, first_channel_flag_oe_n},
            {e.d & e.m, 16'h0000, e.f, 1'b0});
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Whatever the host samples is matched against the oldest note
    always @(u_host.take) begin
        if (exp_q.size() > 0)
            compare_bus(exp_q.pop_front());
        else
            compare_val(34'h1, 34'h0);
    end

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    initial begin
        #200_000;
        compare_val(34'h1, 34'h0);
        results();
    end

    // ----------------------------------------
    // Stimulus tasks
    // ----------------------------------------
    task automatic wait_busy(input logic v);
        @(negedge core_clk);
        for (int k = 0; k < 40 && busy !== v; k++)
            @(negedge core_clk);
        compare_val(busy, v);
        if (busy !== v)
            results();
        @(posedge core_clk);
    endtask

    task automatic conv();
        convert_start_a <= 1'b1;
        repeat (3) @(posedge core_clk);
        convert_start_b <= 1'b1;
        @(posedge core_clk);
        wait_busy(1'b1);
        convert_start_a <= 1'b0;
        convert_start_b <= 1'b0;
        @(posedge core_clk);
        convert_start_a <= 1'b1;
        convert_start_b <= 1'b1;
        wait_busy(1'b0);
        repeat (10) @(negedge core_clk);
        compare_val(busy, 1'b0);
        @(posedge core_clk);
        convert_start_a <= 1'b0;
        convert_start_b <= 1'b0;
    endtask

    // Offers words for up to 30 cycles, stopping early only when the limit is reached
    task automatic fill(input int lim);
        sample_valid <= 1'b1;
        for (int k = 0; k < 30 && n < lim; k++) begin
            sample_data <= res[n];
            @(negedge core_clk);
            if (sample_ready === 1'b1)
                n++;
            @(posedge core_clk);
        end
        sample_valid <= 1'b0;
    endtask

    // Mode 0 word, 1 byte, 2 serial; b is the first result of the conversion
    task automatic frame_check(input int md, input int b);
        logic [23:0] w;
        int idx;
        interface_select <= (md != 0);
        bus15_or_serial_byte_choice <= (md == 1);
        bus14_or_byte_order <= (md == 1) && ord;
        for (int c = 0; c < 8; c++) begin
            w = {res[b + c], 6'h00};
            if (md == 0) begin
                exp_q.push_back({w[23:8], 16'hFFFF, c == 0});
                exp_q.push_back({w[7:6], 14'h0000, 16'hFFFF, c == 0});
            end else if (md == 1) begin
                for (int j = 0; j < 3; j++) begin
                    idx = ord ? j : 2 - j;
                    exp_q.push_back({8'h00, 8'(w >> (16 - 8 * idx)), 16'h00FF, c == 0});
                end
            end else if (c < 4) begin
                for (int k = 17; k >= 0; k--)
                    exp_q.push_back({7'h00, res[b + c + 4][k], res[b + c][k], 7'h00, 16'h0180, c == 0});
            end
        end
        @(posedge core_clk);
        u_host.frame((md == 0) ? 16 : (md == 1) ? 24 : 72, md == 2);
        @(negedge core_clk);
        compare_val({bus_drive.oe_n, first_channel_flag_oe_n}, 34'h1_FFFF);
        compare_val(exp_q.size(), 34'h0);
        @(posedge core_clk);
    endtask

    initial begin
        rst_b = 1'b0;
        oversample_select = 3'h0;
        convert_start_a = 1'b0;
        convert_start_b = 1'b0;
        interface_select = 1'b0;
        bus15_or_serial_byte_choice = 1'b0;
        bus14_or_byte_order = 1'b0;
        sample_valid = 1'b0;
        sample_data = 18'h0_0000;
        checks = 0;
        mismatches = 0;
        n = $urandom(88571);
        n = 0;
        foreach (res[i])
            res[i] = 18'($urandom);
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            oversample_select <= i[2:0];
            repeat (8) @(negedge core_clk);
            compare_val(filter_ratio, (i == 7) ? 34'h1 : 34'h1 << i);
            @(posedge core_clk);
        end
        fill(32);
        compare_val(n, 34'h10);
        // Frames open only after busy has fallen
        conv();
        frame_check(0, 0);
        conv();
        ord = 1'b1;
        frame_check(1, 8);
        fill(32);
        compare_val(n, 34'h20);
        conv();
        ord = 1'b0;
        frame_check(1, 16);
        conv();
        frame_check(2, 24);
        results();
    end
endmodule
